// ### fbep_flash_guard.sv
// Flash array with per-region read/write/erase protection filter.
// Assumes requesters sit on clk; protection levels come from on-chip logic.
`timescale 1ns/1ps

// How it works
// - 64 KB array behind the access filter.
// - 1 KB units erase singly, others untouched.
// - Finished erase leaves unit all ones.
// - Protection per 2 KB region, two units.
// - Regions marked read-only or execute-only.
// - Read-only region refuses erase and program.
// - Execute-only serves reads to fetch only.
// - Execute-only denies data and debug reads.
module fbep_flash_guard
  import fbep_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [2*REGIONS-1:0]   prot_level,
  input  wire logic                   rd_req,
  input  wire logic [1:0]             rd_src,
  input  wire logic [ADDR_W-1:0]      rd_addr,
  output logic                        rd_ack,
  output logic                        rd_denied,
  output logic [WORD_BITS-1:0]        rd_data,
  input  wire logic                   wr_req,
  input  wire logic [ADDR_W-1:0]      wr_addr,
  input  wire logic [WORD_BITS-1:0]   wr_data,
  input  wire logic                   er_req,
  input  wire logic [UNIT_W-1:0]      er_unit,
  output logic                        op_busy,
  output logic                        op_done,
  output logic                        op_denied
);
  logic [WORD_BITS-1:0] mem [WORDS];

  // Each region owns one two-bit field of the level vector.
  function automatic fbep_prot_t region_prot(input logic [2*REGIONS-1:0] lv,
                                             input logic [REGION_W-1:0] r);
    region_prot = fbep_prot_t'(lv[$bits(fbep_prot_t)*r +: $bits(fbep_prot_t)]);
  endfunction : region_prot

  // Only an unmarked region takes a program or an erase; the spare level
  // code counts as locked, which is the safe reading of a corrupt setting.
  function automatic logic may_modify(input fbep_prot_t p);
    may_modify = (p == FBEP_PROT_OPEN);
  endfunction : may_modify

  fbep_state_t          state, next_state;
  logic [UNIT_W-1:0]    unit, next_unit;
  logic [OFS_W-1:0]     ofs, next_ofs;
  logic                 next_busy, next_done, next_denied;
  logic                 next_rd_ack, next_rd_denied;
  logic [WORD_BITS-1:0] next_rd_data;
  logic                 wr_ok, er_ok, rd_ok, mem_we;
  logic [ADDR_W-1:0]    mem_wa;
  logic [WORD_BITS-1:0] mem_wd;
  fbep_prot_t           rd_p, wr_p, er_p;

  always_comb begin
    rd_p = region_prot(prot_level, rd_addr[ADDR_W-1 -: REGION_W]);
    wr_p = region_prot(prot_level, wr_addr[ADDR_W-1 -: REGION_W]);
    er_p = region_prot(prot_level, er_unit[UNIT_W-1 -: REGION_W]);
    // Locked regions refuse modification; open regions take it.
    wr_ok = may_modify(wr_p);
    er_ok = may_modify(er_p);
    // Execute-only contents reach the fetch path and nothing else.
    rd_ok = (rd_p != FBEP_PROT_EXO) || (rd_src == FBEP_SRC_FETCH);
    // Reads are served even while a sweep runs; a word of the unit being
    // erased shows its old value until the sweep has passed it.
    next_rd_ack    = rd_req;
    next_rd_denied = rd_req && !rd_ok;
    next_rd_data   = (rd_req && rd_ok) ? mem[rd_addr] : '0;
    next_state  = state;
    next_unit   = unit;
    next_ofs    = ofs;
    next_busy   = 1'b0;
    next_done   = 1'b0;
    next_denied = 1'b0;
    mem_we      = 1'b0;
    mem_wa      = wr_addr;
    mem_wd      = wr_data;
    case (state)
      FBEP_IDLE: begin
        // Erase takes priority over a program in the same cycle.
        if (er_req) begin
          if (er_ok) begin
            next_state = FBEP_ERASE;
            next_unit  = er_unit;
            next_ofs   = OFS_ZERO;
            next_busy  = 1'b1;
          end else begin
            next_denied = 1'b1;
          end
        end else if (wr_req) begin
          if (wr_ok) begin
            mem_we    = 1'b1;
            next_done = 1'b1;
          end else begin
            next_denied = 1'b1;
          end
        end
      end
      FBEP_ERASE: begin
        // One word per clock; only the chosen unit is addressed.
        // Program and erase requests arriving now are dropped, not queued, so a requester must
        // wait for op_done before it asks again.
        mem_we    = 1'b1;
        mem_wa    = {unit, ofs};
        mem_wd    = ERASED_WORD;
        next_busy = 1'b1;
        next_ofs  = ofs + 1'b1;
        if (ofs == OFS_LAST) begin
          next_state = FBEP_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
        end
      end
      default: next_state = FBEP_IDLE;
    endcase
  end

  // Every output is a flop, so requesters see clean one-cycle pulses and a clean op_busy level.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= FBEP_IDLE;
      unit      <= '0;
      ofs       <= '0;
      op_busy   <= 1'b0;
      op_done   <= 1'b0;
      op_denied <= 1'b0;
      rd_ack    <= 1'b0;
      rd_denied <= 1'b0;
      rd_data   <= '0;
    end else begin
      state     <= next_state;
      unit      <= next_unit;
      ofs       <= next_ofs;
      op_busy   <= next_busy;
      op_done   <= next_done;
      op_denied <= next_denied;
      rd_ack    <= next_rd_ack;
      rd_denied <= next_rd_denied;
      rd_data   <= next_rd_data;
    end
  end

  // The array has no reset; contents survive like real flash.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Every served read from an open or read-only region, and every execute-only fetch, is checked against the array as it stood at the request
  // edge, because a sweep may rewrite the same word at that very edge.
  chk_exo_read_deny: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_src != FBEP_SRC_FETCH && rd_p == FBEP_PROT_EXO |=> rd_denied && rd_data == '0)
    else $error("execute-only read served to non-fetch");
  chk_fetch_exo_ok: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_src == FBEP_SRC_FETCH |=> rd_ack && !rd_denied)
    else $error("fetch refused");
  chk_locked_erase_deny: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && er_req && er_p != FBEP_PROT_OPEN |=> op_denied && !op_busy)
    else $error("erase of locked region not refused");
  chk_locked_prog_deny: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && !er_req && wr_req && wr_p != FBEP_PROT_OPEN |=> op_denied)
    else $error("program of locked region not refused");
  chk_open_prog_ok: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && !er_req && wr_req && wr_p == FBEP_PROT_OPEN
    |=> op_done && mem[$past(wr_addr)] == $past(wr_data))
    else $error("open program not done");
  chk_erase_ones: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_ERASE |=> mem[$past(mem_wa)] == ERASED_WORD)
    else $error("erased word not all ones");
  chk_erase_unit: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_ERASE |-> mem_wa[ADDR_W-1 -: UNIT_W] == unit)
    else $error("erase left its unit");
  chk_erase_len: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && er_req && er_ok |=> op_busy ##256 op_done && !op_busy)
    else $error("erase length wrong");
  chk_open_data_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_p == FBEP_PROT_OPEN |=> !rd_denied && rd_data == $past(mem[rd_addr]))
    else $error("open read refused");

  chk_read_answer: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req |=> rd_ack)
    else $error("read not answered");
  chk_plain_read_ok: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_p != FBEP_PROT_EXO |=> !rd_denied)
    else $error("read outside execute-only region refused");
  chk_rdo_read_ok: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_p == FBEP_PROT_RDO
    |=> rd_ack && !rd_denied && rd_data == $past(mem[rd_addr]))
    else $error("read-only region not readable");
  chk_exo_fetch_data: assert property (@(posedge clk) disable iff (!rst_b)
    rd_req && rd_src == FBEP_SRC_FETCH && rd_p == FBEP_PROT_EXO
    |=> rd_data == $past(mem[rd_addr]))
    else $error("fetch from execute-only region got wrong data");
  chk_idle_read_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !rd_req |=> !rd_ack && !rd_denied && rd_data == '0)
    else $error("read reply without a request");
  chk_denied_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && !er_req && wr_req && !wr_ok
    |=> mem[$past(wr_addr)] == $past(mem[wr_addr]))
    else $error("refused program changed the array");
  chk_erase_start: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && er_req && er_ok
    |=> state == FBEP_ERASE && unit == $past(er_unit) && ofs == OFS_ZERO)
    else $error("erase started on the wrong unit");
  chk_open_erase_go: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_IDLE && er_req && er_p == FBEP_PROT_OPEN |=> op_busy && !op_denied)
    else $error("open erase refused");
  chk_busy_silent: assert property (@(posedge clk) disable iff (!rst_b)
    state == FBEP_ERASE |=> !op_denied)
    else $error("request during erase answered");

  cov_erase: cover property (@(posedge clk) disable iff (!rst_b) op_done && !op_busy);
  cov_exo_deny: cover property (@(posedge clk) disable iff (!rst_b) rd_denied);
  cov_op_deny: cover property (@(posedge clk) disable iff (!rst_b) op_denied);
  cov_rdo_read: cover property (@(posedge clk) disable iff (!rst_b)
    rd_ack && !rd_denied && $past(rd_p) == FBEP_PROT_RDO);
  cov_read_in_erase: cover property (@(posedge clk) disable iff (!rst_b)
    op_busy && rd_ack);
endmodule : fbep_flash_guard

// ### fbep_pkg.sv
// Package for the flash block erase and protection logic.
// Assumes a single system clock domain; shared by the design module, the requester model and the bench.
package fbep_pkg;
  localparam int FLASH_BYTES  = 65536;
  localparam int UNIT_BYTES   = 1024;
  localparam int REGION_UNITS = 2;
  localparam int WORD_BYTES   = 4;
  localparam int WORD_BITS    = 32;
  localparam int WORDS        = FLASH_BYTES / WORD_BYTES;
  localparam int UNITS        = FLASH_BYTES / UNIT_BYTES;
  localparam int REGIONS      = UNITS / REGION_UNITS;
  localparam int ADDR_W       = $clog2(WORDS);
  localparam int UNIT_W       = $clog2(UNITS);
  localparam int REGION_W     = $clog2(REGIONS);
  localparam int UNIT_WORDS   = UNIT_BYTES / WORD_BYTES;
  localparam int OFS_W        = $clog2(UNIT_WORDS);
  localparam logic [WORD_BITS-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [OFS_W-1:0]     OFS_LAST    = 8'hFF;
  localparam logic [OFS_W-1:0]     OFS_ZERO    = 8'h00;

  // Requesters of a read.
  typedef enum logic [1:0] {
    FBEP_SRC_FETCH = 2'h0,
    FBEP_SRC_DATA  = 2'h1,
    FBEP_SRC_DEBUG = 2'h2
  } fbep_src_t;

  // Protection level of a 2 KB region.
  typedef enum logic [1:0] {
    FBEP_PROT_OPEN  = 2'h0,
    FBEP_PROT_RDO   = 2'h1,
    FBEP_PROT_EXO   = 2'h2
  } fbep_prot_t;

  typedef enum logic [1:0] {
    FBEP_IDLE  = 2'h0,
    FBEP_ERASE = 2'h1
  } fbep_state_t;
endpackage : fbep_pkg

// ### fbep_req_model.sv
// Requester model: fetch, data and debug reads plus program and erase.
// Assumes calls from the bench; every request spans one rising edge.
`timescale 1ns/1ps
module fbep_req_model
  import fbep_pkg::*;
(
  input  wire logic            clk,
  output logic                 rd_req,
  output logic [1:0]           rd_src,
  output logic                 wr_req,
  output logic                 er_req,
  output logic [ADDR_W-1:0]    addr,
  output logic [WORD_BITS-1:0] data
);
  initial {rd_req, rd_src, wr_req, er_req, addr, data} = '0;
  task automatic issue(input logic [1:0] op, input logic [1:0] src,
                       input logic [ADDR_W-1:0] a, input logic [WORD_BITS-1:0] d);
    @(negedge clk);
    {rd_src, addr, data} = {src, a, d};
    {rd_req, wr_req, er_req} = {op == 2'h0, op == 2'h1, op == 2'h2};
    @(negedge clk);
    {rd_req, wr_req, er_req} = 3'h0;
    // Released lines are inverted so a stale value never looks valid.
    {addr, data} = {~a, ~d};
  endtask : issue
endmodule : fbep_req_model

// ### test_fbep_flash_guard.sv
// Self-checking bench for the flash guard: table of cases, then hand tests.
// Assumes the requester model drives every request pin of the design.
`timescale 1ns/1ps
module test_fbep_flash_guard;
  import fbep_pkg::*;
  typedef struct packed {
    logic lk; logic [1:0] op; logic [1:0] src; logic [13:0] a;
    logic [31:0] d; logic deny; logic [31:0] q;
  } fbep_row_t;
  logic clk = 1'b0, rst_b = 1'b0, rd_req, wr_req, er_req;
  logic rd_ack, rd_denied, op_busy, op_done, op_denied;
  logic [63:0] prot_level = 64'h0;
  logic [1:0] rd_src;
  logic [13:0] addr;
  logic [31:0] data, rd_data;
  int errors = 0, cmp_count = 0;
  fbep_row_t rows[$];
  // Region 0 open, 1 read-only, 2 execute-only, 3 the spare code.
  localparam logic [63:0] LOCK_MAP = 64'hE4;
  always #4 clk = ~clk;
  fbep_req_model REQ (.clk(clk), .rd_req(rd_req), .rd_src(rd_src), .wr_req(wr_req),
    .er_req(er_req), .addr(addr), .data(data));
  fbep_flash_guard DUT (.clk(clk), .rst_b(rst_b), .prot_level(prot_level),
    .rd_req(rd_req), .rd_src(rd_src), .rd_addr(addr), .rd_ack(rd_ack),
    .rd_denied(rd_denied), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(addr),
    .wr_data(data), .er_req(er_req), .er_unit(addr[13:8]), .op_busy(op_busy),
    .op_done(op_done), .op_denied(op_denied));
  function automatic fbep_row_t mk(int lk, int op, int src, int a, int d, int dn, int q);
    mk = {lk[0], op[1:0], src[1:0], a[13:0], d, dn[0], q};
  endfunction : mk
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // For program and erase rows, q holds the expected cycles to completion.
  task automatic do_row(input fbep_row_t r);
    int n;
    prot_level = r.lk ? LOCK_MAP : 64'h0;
    REQ.issue(r.op, r.src, r.a, r.d);
    if (r.op == 2'h0) begin
      check("rd_ack", 32'h1, {31'h0, rd_ack});
      check("rd_denied", {31'h0, r.deny}, {31'h0, rd_denied});
      check("rd_data", r.q, rd_data);
    end else begin
      for (n = 1; !(op_done | op_denied) && n < 300; n++) @(negedge clk);
      check("op_denied", {31'h0, r.deny}, {31'h0, op_denied});
      check("op_cycles", r.q, n);
      if (n >= 300) stop_test();
    end
  endtask : do_row
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    check("idle_outputs", 32'h0, {rd_ack, rd_denied, op_busy, op_done, op_denied});
    rows = '{mk(0, 1, 0, 'h100, 'hA5A5A5A5, 0, 1), mk(0, 1, 0, 'h400, 'h5A5A5A5A, 0, 1),
      mk(0, 1, 0, 'h600, 'h0F0F0F0F, 0, 1), mk(0, 1, 0, 'h200, 'hC3C3C3C3, 0, 1),
      mk(1, 2, 0, 'h005, 0, 0, 257), mk(1, 0, 1, 'h005, 0, 0, 'hFFFFFFFF),
      mk(1, 0, 2, 'h0FF, 0, 0, 'hFFFFFFFF), mk(1, 0, 0, 'h100, 0, 0, 'hA5A5A5A5),
      mk(1, 1, 0, 'h005, 'h12345678, 0, 1), mk(1, 0, 2, 'h005, 0, 0, 'h12345678),
      mk(1, 1, 0, 'h200, 'h1, 1, 1), mk(1, 0, 1, 'h200, 0, 0, 'hC3C3C3C3),
      mk(1, 2, 0, 'h200, 0, 1, 1), mk(1, 0, 2, 'h200, 0, 0, 'hC3C3C3C3),
      mk(1, 2, 0, 'h400, 0, 1, 1), mk(1, 1, 0, 'h400, 'h1, 1, 1),
      mk(1, 0, 0, 'h400, 0, 0, 'h5A5A5A5A), mk(1, 0, 1, 'h400, 0, 1, 0),
      mk(1, 0, 2, 'h4FF, 0, 1, 0), mk(1, 0, 1, 'h600, 0, 0, 'h0F0F0F0F),
      mk(1, 1, 0, 'h600, 'h1, 1, 1), mk(1, 0, 1, 'h600, 0, 0, 'h0F0F0F0F)};
    foreach (rows[i]) do_row(rows[i]);
    // A read while an erase runs is still answered in one cycle.
    REQ.issue(2'h2, 2'h0, 14'h0100, 32'h0);
    do_row(mk(1, 0, 0, 'h005, 0, 0, 'h12345678));
    check("op_busy", 32'h1, {31'h0, op_busy});
    // An erase asked four edges into a sweep is dropped: done follows the
    // first sweep of 256 words, which is 252 edges after this request.
    do_row(mk(1, 2, 0, 'h100, 0, 0, 253));
    do_row(mk(1, 0, 1, 'h1FF, 0, 0, 'hFFFFFFFF));
    check("op_busy_after", 32'h0, {31'h0, op_busy});
    // Reset in the middle of a sweep abandons it; the next program is taken.
    REQ.issue(2'h2, 2'h0, 14'h0000, 32'h0);
    repeat (3) @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    check("reset_outputs", 32'h0, {rd_ack, rd_denied, op_busy, op_done, op_denied});
    rst_b = 1'b1;
    do_row(mk(1, 1, 0, 'h010, 'h3C3C3C3C, 0, 1));
    do_row(mk(1, 0, 1, 'h010, 0, 0, 'h3C3C3C3C));
    stop_test();
  end
endmodule : test_fbep_flash_guard
